// ### src/wwcm_pkg.sv
// constants for the windowed watchdog with clock monitor
// assumes an APB master on the core clock and idle-timer ticks from the same clock
package wwcm_pkg;
   // ==============================
   // register map
   localparam logic [7:0] WWCM_OFS_SERVICE = 8'h00;
   localparam logic [7:0] WWCM_OFS_STATUS = 8'h04;
   // ==============================
   // service word layout
   localparam int WWCM_WIN_MSB = 7;
   localparam int WWCM_WIN_LSB = 6;
   localparam int WWCM_KEY_MSB = 5;
   localparam int WWCM_KEY_LSB = 1;
   localparam int WWCM_CM_BIT = 0;
   localparam logic [4:0] WWCM_KEY = 5'h0C;
   localparam logic [1:0] WWCM_WIN_RESET = 2'h3;
   localparam logic WWCM_CM_RESET = 1'b1;
   // ==============================
   // status layout
   localparam int WWCM_ST_CONF = 0;
   localparam int WWCM_ST_WDERR = 1;
   localparam int WWCM_ST_CMERR = 2;
   localparam int WWCM_ST_LSUPP = 3;
   localparam int WWCM_ST_ENA = 4;
   // ==============================
   // window limits in idle-timer clocks
   localparam int WWCM_CW = 17;
   localparam logic [16:0] WWCM_LOWER = 17'h00800;
   localparam logic [16:0] WWCM_UP_8K = 17'h02000;
   localparam logic [16:0] WWCM_UP_16K = 17'h04000;
   localparam logic [16:0] WWCM_UP_32K = 17'h08000;
   localparam logic [16:0] WWCM_UP_64K = 17'h10000;
   // ==============================
   // fault pulse and clock monitor timing
   localparam logic [4:0] WWCM_RELEASE_EDGES = 5'h10;
   localparam int WWCM_CLK_PERIOD_NS = 8;
   localparam int WWCM_CM_LIMIT_NS = 1000000;
   localparam int WWCM_CM_LIMIT_CYCLES = WWCM_CM_LIMIT_NS / WWCM_CLK_PERIOD_NS;

   typedef enum logic [1:0] {WWCM_IDLE, WWCM_PULL, WWCM_HOLD, WWCM_RISE} wwcm_wd_e;
endpackage

// ### src/wwcm_top.sv
// windowed watchdog, clock monitor and fault pin driver behind an APB slave
// assumes tick inputs come from core logic; the pin and instruction clock are asynchronous
//
// What this block does
// - lower service limit is 2048 idle-timer clocks for any window.
// - window bits 7:6 select upper limit 8k, 16k, 32k or 64k.
// - key field bits 5:1 must equal 01100 on every service write.
// - bit 0 enables the clock monitor when one.
// - window time counts idle-timer clock ticks.
// - watchdog runs only when option bit 2 is zero; then it owns the pin.
// - after reset window bits are 11 and clock monitor is on.
// - both detectors are held inhibited during reset.
// - first keyed write after reset fixes window and monitor enable for good.
// - later writes must match all eight stored bits or raise an error.
// - full match is a valid service and restarts the window.
// - no valid service before upper limit raises an error.
// - service before lower limit raises an error.
// - boot entry suppresses lower error and services immediately.
// - fault pin is active low, pulled up weakly when idle.
// - on error pull low, hold 16 to 32 cycles after low is sensed.
// - window restarts when the pin returns high after a pulse.
// - service writes during an active fault are ignored.
// - a pin low at power-up lets the watchdog time out, then it rises.
// - clock error pulls pin low until clock valid, then 16 to 32 cycles.
// - instruction clock above 5 kHz passes, below 10 Hz is rejected.
// - missing or slow oscillator gives continuous monitor error, also after reset.
// - reading the key field returns zeros.
// - watchdog detector is inhibited in halt and idle.
// - clock monitor stays active in halt and idle.
// - leaving idle performs a hardware service.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module wwcm_top
   import wwcm_pkg::*;
#(
   parameter int CM_LIMIT = WWCM_CM_LIMIT_CYCLES
)
(
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_option_wd_n,
   input wire logic i_idle_timebase,
   input wire logic i_halt,
   input wire logic i_idle,
   input wire logic i_idle_exit,
   input wire logic i_boot_entry,
   input wire logic i_boot_exit,
   input wire logic i_inst_clk,
   input wire logic i_fault_port_pin,
   output logic o_watchdog_fault_out,
   output logic o_watchdog_fault_oe,
   output logic o_fault_pullup_en
);
   // ==============================
   // input synchronisers
   logic [1:0] raw_in;
   logic [1:0] sync_filt;
   assign raw_in = {i_inst_clk, i_fault_port_pin};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_sync
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic filt_q;
         always_ff @(posedge i_mclk)
         begin
            s1_q <= raw_in[gi];
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (i_reset)
               filt_q <= 1'b1;
            else if (s2_q == s3_q)
               filt_q <= s3_q;
         end
         assign sync_filt[gi] = filt_q;
      end
   endgenerate

   logic pin_level;
   logic tc_level_q;
   logic tc_edge;
   assign pin_level = sync_filt[0];
   assign tc_edge = sync_filt[1] & ~tc_level_q;

   // ==============================
   // functions
   function automatic logic [16:0] upper_limit(input logic [1:0] sel);
      unique case (sel)
         2'h0: upper_limit = WWCM_UP_8K;
         2'h1: upper_limit = WWCM_UP_16K;
         2'h2: upper_limit = WWCM_UP_32K;
         2'h3: upper_limit = WWCM_UP_64K;
      endcase
   endfunction

   // ==============================
   // APB decode
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic access;
   logic hit_svc;
   logic hit_st;
   logic svc_wr;
   assign access = i_psel & i_penable & ~pready_q;
   assign hit_svc = (i_paddr == WWCM_OFS_SERVICE);
   assign hit_st = (i_paddr == WWCM_OFS_STATUS);
   assign svc_wr = i_psel & i_penable & pready_q & i_pwrite & hit_svc;

   // ==============================
   // watchdog state
   logic [1:0] win_q;
   logic cm_en_q;
   logic conf_q;
   logic lsupp_q;
   logic [16:0] cnt_q;
   logic [16:0] cnt_d;
   logic wd_err_q;
   logic cm_err_q;
   logic [4:0] rel_q;
   logic [4:0] cm_rel_q;
   logic [16:0] cm_cnt_q;
   wwcm_wd_e st_q;
   wwcm_wd_e st_d;

   logic wd_en;
   logic wd_run;
   logic fault_act;
   logic [4:0] wr_key;
   logic key_ok;
   logic full_ok;
   logic early;
   logic svc_take;
   logic svc_bad;
   logic timeout;
   logic wd_trip;
   logic hw_service;
   logic restart;
   logic cm_slow;
   assign wd_en = ~i_option_wd_n;
   assign wd_run = wd_en & ~i_halt & ~i_idle;
   assign fault_act = wd_err_q | cm_err_q;
   assign wr_key = i_pwdata[WWCM_KEY_MSB:WWCM_KEY_LSB];
   assign key_ok = (wr_key == WWCM_KEY);
   assign full_ok = key_ok & (i_pwdata[WWCM_WIN_MSB:WWCM_WIN_LSB] == win_q)
                    & (i_pwdata[WWCM_CM_BIT] == cm_en_q);
   assign early = conf_q & ~lsupp_q & (cnt_q < WWCM_LOWER);
   assign svc_take = svc_wr & wd_run & ~fault_act;
   assign svc_bad = svc_take & (conf_q ? (~full_ok | early) : ~key_ok);
   assign timeout = wd_run & (cnt_q >= upper_limit(win_q));
   assign wd_trip = (st_q == WWCM_IDLE) & (svc_bad | timeout);
   assign hw_service = i_idle_exit | i_boot_entry | i_boot_exit;
   assign restart = (svc_take & ~svc_bad) | hw_service
                    | ((st_q == WWCM_RISE) & pin_level);
   assign cm_slow = (cm_cnt_q == CM_LIMIT[16:0]);

   always_comb
   begin
      cnt_d = cnt_q;
      if (restart)
         cnt_d = '0;
      else if (wd_run & i_idle_timebase & (st_q == WWCM_IDLE) & ~timeout)
         cnt_d = cnt_q + 17'h00001;
   end

   // error pulse sequencer
   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         WWCM_IDLE: if (wd_trip) st_d = WWCM_PULL;
         WWCM_PULL: if (~pin_level) st_d = WWCM_HOLD;
         WWCM_HOLD: if (rel_q == WWCM_RELEASE_EDGES) st_d = WWCM_RISE;
         WWCM_RISE: if (pin_level) st_d = WWCM_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         // matches the filter reset level, so no false edge after reset
         tc_level_q <= 1'b1;
         win_q <= WWCM_WIN_RESET;
         cm_en_q <= WWCM_CM_RESET;
         conf_q <= 1'b0;
         lsupp_q <= 1'b0;
         cnt_q <= '0;
         st_q <= WWCM_IDLE;
         wd_err_q <= 1'b0;
         rel_q <= '0;
      end
      else
      begin
         tc_level_q <= sync_filt[1];
         cnt_q <= cnt_d;
         st_q <= st_d;
         if (svc_take & ~conf_q & key_ok)
         begin
            win_q <= i_pwdata[WWCM_WIN_MSB:WWCM_WIN_LSB];
            cm_en_q <= i_pwdata[WWCM_CM_BIT];
            conf_q <= 1'b1;
         end
         if (i_boot_entry)
            lsupp_q <= 1'b1;
         else if (i_boot_exit)
            lsupp_q <= 1'b0;
         if (wd_trip)
            wd_err_q <= 1'b1;
         else if (st_d == WWCM_RISE)
            wd_err_q <= 1'b0;
         if (st_q != WWCM_HOLD)
            rel_q <= '0;
         else if (tc_edge)
            rel_q <= rel_q + 5'h01;
      end
   end

   // ==============================
   // clock monitor
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         cm_cnt_q <= '0;
         cm_err_q <= 1'b0;
         cm_rel_q <= '0;
      end
      else
      begin
         if (tc_edge)
            cm_cnt_q <= '0;
         else if (~cm_slow)
            cm_cnt_q <= cm_cnt_q + 17'h00001;
         if (wd_en & cm_en_q & cm_slow)
            cm_err_q <= 1'b1;
         else if (~(wd_en & cm_en_q) | (cm_rel_q == WWCM_RELEASE_EDGES))
            cm_err_q <= 1'b0;
         if (~cm_err_q | cm_slow)
            cm_rel_q <= '0;
         else if (tc_edge)
            cm_rel_q <= cm_rel_q + 5'h01;
      end
   end

   // ==============================
   // pin drive and bus answer
   logic drive_q;
   logic pullup_q;
   logic [31:0] rd_val;
   assign rd_val = hit_svc ? {24'h000000, win_q, 5'h00, cm_en_q} :
                   hit_st ? {27'h0000000, wd_en, lsupp_q, cm_err_q, wd_err_q, conf_q} :
                   32'h00000000;

   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         drive_q <= 1'b0;
         pullup_q <= 1'b0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end
      else
      begin
         drive_q <= (wd_err_q & (st_q != WWCM_RISE)) | cm_err_q;
         pullup_q <= wd_en;
         pready_q <= access;
         pslverr_q <= access & (~(hit_svc | hit_st) | (hit_st & i_pwrite));
         if (access)
            prdata_q <= i_pwrite ? 32'h00000000 : rd_val;
      end
   end

   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
   assign o_watchdog_fault_out = 1'b0;
   assign o_watchdog_fault_oe = drive_q;
   assign o_fault_pullup_en = pullup_q;

   // ==============================
   // checks
   initial_window_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      !conf_q |-> (win_q == WWCM_WIN_RESET && cm_en_q == WWCM_CM_RESET))
      else $error("window not at maximum before first service");
   lock_fields_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      conf_q && $past(conf_q) |-> $stable(win_q) && $stable(cm_en_q))
      else $error("fields changed after first service");
   early_error_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      svc_take && conf_q && !lsupp_q && cnt_q < WWCM_LOWER && st_q == WWCM_IDLE
      |=> wd_err_q)
      else $error("early service not flagged");
   bad_key_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      svc_take && !key_ok && st_q == WWCM_IDLE |=> wd_err_q)
      else $error("bad key not flagged");
   good_service_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      svc_take && !svc_bad |=> cnt_q == '0)
      else $error("valid service did not restart window");
   timeout_error_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      wd_run && st_q == WWCM_IDLE && cnt_q >= upper_limit(win_q) |=> wd_err_q)
      else $error("upper limit expiry not flagged");
   ignore_fault_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      svc_wr && fault_act |=> $stable(conf_q) && $stable(win_q))
      else $error("service taken during fault");
   key_hidden_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_pready && hit_svc |-> o_prdata[WWCM_KEY_MSB:WWCM_KEY_LSB] == 5'h00)
      else $error("key readable");
   hold_release_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      st_q == WWCM_PULL && !pin_level |=> st_q == WWCM_HOLD ##1 o_watchdog_fault_oe)
      else $error("fault released before hold");
   halt_freeze_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_halt || i_idle) && !restart |=> $stable(cnt_q))
      else $error("watchdog counted in low power");
   cm_drive_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      wd_en && cm_en_q && cm_slow |=> ##1 o_watchdog_fault_oe)
      else $error("clock error not driven");
   fault_or_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      cm_err_q |=> o_watchdog_fault_oe)
      else $error("monitor flag not on pin");
endmodule

// ### testbench/testbench.sv
// self-checking bench for the windowed watchdog and clock monitor
// assumes the pin model above and a core clock of 125 MHz
`timescale 1ns/1ns
module testbench;
   import wwcm_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, tick = 1'b0, boot = 1'b0;
   logic iclk = 1'b0, irun = 1'b1;
   logic idl = 1'b0, iex = 1'b0;
   logic [1:0] div = 2'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, perr, oe, pu, fout, pin;
   int error_cnt = 0, num_checks = 0, fw, fl;
   // ==============================
   // clocks and stimulus sources
   initial forever #4 mclk = ~mclk;
   // idle-timer tick every other core cycle, instruction clock a quarter
   always @(posedge mclk)
   begin
      tick <= ~tick;
      div <= div + 2'h1;
      if (irun) iclk <= div[1];
   end
   wwcm_top #(.CM_LIMIT(200)) wwcm_top_i (.i_mclk(mclk), .i_reset(rst), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_option_wd_n(1'b0), .i_idle_timebase(tick),
      .i_halt(1'b0), .i_idle(idl), .i_idle_exit(iex), .i_boot_entry(boot),
      .i_boot_exit(1'b0), .i_inst_clk(iclk), .i_fault_port_pin(pin),
      .o_watchdog_fault_out(fout), .o_watchdog_fault_oe(oe), .o_fault_pullup_en(pu));
   wwcm_pin_model wwcm_pin_model_i (.i_mclk(mclk), .i_oe(oe), .i_val(fout),
      .i_pullup_en(pu), .o_pin(pin));
   // ==============================
   // tasks
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] rng(input int v, input int lo, input int hi);
      return {31'h0, (v >= lo && v <= hi)};
   endfunction
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      pen <= 1'b1;
      do
      begin
         @(posedge mclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // wait for a fault pulse, then time its length
   task fault(input int lim);
      fw = 0;
      fl = 0;
      while (oe !== 1'b1 && fw < lim)
      begin
         @(posedge mclk);
         fw++;
      end
      while (oe === 1'b1 && fl < 400)
      begin
         @(posedge mclk);
         fl++;
      end
      repeat (8) @(posedge mclk);
   endtask
   // ==============================
   // tests
   initial
   begin
      #800000;
      error_cnt++;
      end_sim;
   end
   initial
   begin
      repeat (20) @(posedge mclk);
      chk({31'h0, oe}, 32'h0);
      rst <= 1'b0;
      apb(1'b0, WWCM_OFS_SERVICE, 32'h0);
      chk(rd, 32'h000000C1);
      apb(1'b0, WWCM_OFS_STATUS, 32'h0);
      chk(rd, 32'h00000010);
      chk({31'h0, pu}, 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk({31'h0, perr}, 32'h1);
      apb(1'b1, WWCM_OFS_STATUS, 32'h0);
      chk({31'h0, perr}, 32'h1);
      apb(1'b1, WWCM_OFS_SERVICE, 32'h00000019);
      apb(1'b0, WWCM_OFS_SERVICE, 32'h0);
      chk(rd, 32'h00000001);
      apb(1'b0, WWCM_OFS_STATUS, 32'h0);
      chk(rd, 32'h00000011);
      repeat (4400) @(posedge mclk);
      apb(1'b1, WWCM_OFS_SERVICE, 32'h00000019);
      repeat (10) @(posedge mclk);
      chk({31'h0, oe}, 32'h0);
      apb(1'b1, WWCM_OFS_SERVICE, 32'h00000019);
      fault(300);
      chk(rng(fw, 0, 4), 32'h1);
      chk(rng(fl, 60, 140), 32'h1);
      repeat (4400) @(posedge mclk);
      apb(1'b1, WWCM_OFS_SERVICE, 32'h00000059);
      fault(300);
      chk(rng(fw, 0, 4), 32'h1);
      chk(rng(fl, 60, 140), 32'h1);
      fault(17000);
      chk(rng(fw, 16360, 16400), 32'h1);
      irun <= 1'b0;
      fork
         fault(300);
         begin
            repeat (300) @(posedge mclk);
            irun <= 1'b1;
         end
      join
      chk(rng(fw, 195, 215), 32'h1);
      chk(rng(fl, 150, 190), 32'h1);
      // count past the lower limit, then idle: a bad write must be ignored
      repeat (4400) @(posedge mclk);
      idl <= 1'b1;
      apb(1'b1, WWCM_OFS_SERVICE, 32'h00000059);
      repeat (10) @(posedge mclk);
      chk({31'h0, oe}, 32'h0);
      // leaving idle services, so a prompt service is early
      idl <= 1'b0;
      iex <= 1'b1;
      @(posedge mclk);
      iex <= 1'b0;
      apb(1'b1, WWCM_OFS_SERVICE, 32'h00000019);
      fault(300);
      chk(rng(fw, 0, 4), 32'h1);
      chk(rng(fl, 60, 140), 32'h1);
      boot <= 1'b1;
      @(posedge mclk);
      boot <= 1'b0;
      apb(1'b1, WWCM_OFS_SERVICE, 32'h00000019);
      repeat (10) @(posedge mclk);
      chk({31'h0, oe}, 32'h0);
      apb(1'b0, WWCM_OFS_STATUS, 32'h0);
      chk({31'h0, rd[WWCM_ST_LSUPP]}, 32'h1);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b1, WWCM_OFS_SERVICE, 32'h00000001);
      fault(300);
      chk(rng(fw, 0, 4), 32'h1);
      chk(rng(fl, 60, 140), 32'h1);
      end_sim;
   end
endmodule

// ### testbench/wwcm_pin_model.sv
// open-drain fault pin with its switchable pull-up
// assumes the block drives low only while its enable is high
`timescale 1ns/1ns
module wwcm_pin_model
(
   input wire logic i_mclk,
   input wire logic i_oe,
   input wire logic i_val,
   input wire logic i_pullup_en,
   output logic o_pin
);
   // ==============================
   // pin level
   // floating pin without pull-up shows a changing level
   logic float_q = 1'b0;
   always_ff @(posedge i_mclk)
   begin
      float_q <= ~float_q;
   end
   assign o_pin = i_oe ? i_val : (i_pullup_en ? 1'b1 : float_q);
endmodule
